// ### src/ppport_core.sv
// Module: printer port pin logic with Avalon-MM register slave
//
// Behaviour
// - Line feed output is the inverse of control bit 1.
// - Data strobe output is low while control bit 0 is set or the EPP strobe pulse runs.
// - Valid port data is signalled by an active-low strobe pulse.
// - Status bit 7 reads the inverted busy input.
// - Status bit 6 reads the acknowledge input uninverted.
// - Status bit 5 reads the paper-out input as is.
// - Status bit 4 reads the online input as is.
// - Status bit 3 reads the fault input as is.
// - An 8-bit two-way port data bus carries bytes both ways.
// - In EPP mode the ready line is pulled low to stretch cycles.
// - Select output is the inverse of control bit 3.
// - Init output follows control bit 2 directly.
// - Interrupt output is gated by control bit 4.
`timescale 1ns/1ps
`default_nettype none
module ppport_core (
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [ppport_pkg::AddrW-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  output logic avsResponseErr,
  // Peripheral side
  output logic line_feed_out_n,
  output logic data_strobe_out_n,
  output logic peripheral_select_out_n,
  output logic peripheral_init_out_n,
  input wire logic peripheral_busy_in,
  input wire logic peripheral_ack_in_n,
  input wire logic paper_out_in,
  input wire logic peripheral_online_in,
  input wire logic peripheral_fault_in_n,
  input wire logic [7:0] port_data_bus_in,
  output logic [7:0] port_data_bus_out,
  output logic port_data_bus_oe,
  output logic port_irq_out,
  output logic channel_ready_out,
  output logic channel_ready_oe
);
  import ppport_pkg::*;

  logic rstSync1_reg;
  logic rstSync2_reg;
  wire rstnInt;
  logic [4:0] pinSync1_reg;
  logic [4:0] pinSync2_reg;
  logic [7:0] dataSync1_reg;
  logic [7:0] dataSync2_reg;
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic [7:0] data_reg;
  logic [7:0] mode_reg;
  logic [31:0] rdData_reg;
  logic ackDone_reg;
  logic [3:0] pulseCnt_reg;
  logic pulseStrobe_reg;
  logic [7:0] sendByte_reg;
  ppport_state_t state_reg;
  ppport_state_t state_next;
  ppport_fifo_if fifoBus ();

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end
  assign rstnInt = rstSync2_reg;

  // Status pins come from outside, so two flops before any use
  // Reset to idle levels, so no false acknowledge or fault after reset
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      pinSync1_reg <= 5'h0B;
      pinSync2_reg <= 5'h0B;
    end else begin
      pinSync1_reg <= {peripheral_busy_in, peripheral_ack_in_n, paper_out_in,
        peripheral_online_in, peripheral_fault_in_n};
      pinSync2_reg <= pinSync1_reg;
    end
  end

  // Port data pins, synchronised the same way for reversed reads
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      dataSync1_reg <= 8'h00;
      dataSync2_reg <= 8'h00;
    end else begin
      dataSync1_reg <= port_data_bus_in;
      dataSync2_reg <= dataSync1_reg;
    end
  end

  // Synchronised status pins
  wire busySync = pinSync2_reg[4];
  wire ackSyncN = pinSync2_reg[3];
  wire paperSync = pinSync2_reg[2];
  wire onlineSync = pinSync2_reg[1];
  wire faultSyncN = pinSync2_reg[0];

  // Status byte: busy inverted, the rest as seen on the pins
  wire [7:0] statusByte;
  assign statusByte[StBusy] = ~busySync;
  assign statusByte[StAck] = ackSyncN;
  assign statusByte[StPaper] = paperSync;
  assign statusByte[StOnline] = onlineSync;
  assign statusByte[StFault] = faultSyncN;
  assign statusByte[2:0] = 3'h0;

  // Bus decode
  wire eppMode = mode_reg[ModeEpp];
  wire dirIn = ctl_reg[CtlDirIn];
  wire hitData = (avsAddress == RegData);
  wire hitStatus = (avsAddress == RegStatus);
  wire hitCtl = (avsAddress == RegControl);
  wire hitMode = (avsAddress == RegMode);
  wire hitFifo = (avsAddress == RegFifo);
  wire hitAny = hitData | hitStatus | hitCtl | hitMode | hitFifo;
  wire lane0 = avsByteenable[0];
  // EPP data writes go through the FIFO and stall while it is full
  wire eppPush = eppMode && hitData && avsWrite && !dirIn;
  wire pushStall = eppPush && !fifoBus.inReady;
  wire reqLive = avsRead | avsWrite;

  // Wait one cycle for every access so read data comes from a flop
  assign avsWaitrequest = reqLive && (!ackDone_reg || pushStall);
  wire accept = reqLive && !avsWaitrequest;
  // Accepted writes and first-cycle reads, one strobe each
  wire wrAccept = accept && avsWrite && lane0;
  wire wrData = wrAccept && hitData;
  wire wrMode = wrAccept && hitMode;
  wire rdFirst = avsRead && !ackDone_reg;
  wire ackSet = reqLive && !accept && !ackDone_reg;
  assign avsReaddata = rdData_reg;
  assign avsResponseErr = 1'b0;

  // Readback mux
  wire [7:0] dataView = dirIn ? dataSync2_reg : data_reg;
  wire [7:0] rdMux = hitData ? dataView :
                     hitStatus ? statusByte :
                     hitCtl ? ctl_reg :
                     hitMode ? mode_reg :
                     hitFifo ? {4'h0, fifoBus.level} : 8'h00;

  // Control register keeps the last write byte lane 0
  assign ctl_next = (avsWrite && hitCtl && lane0 && !avsWaitrequest) ?
                    avsWritedata[7:0] : ctl_reg;

  // One-cycle wait state, cleared as the request is taken
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      ackDone_reg <= 1'b0;
    end else begin
      ackDone_reg <= ackSet ? 1'b1 : (accept ? 1'b0 : ackDone_reg);
    end
  end

  // Read data from a flop, so it stands while waitrequest is low
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      rdData_reg <= 32'h00000000;
    end else if (rdFirst) begin
      rdData_reg <= {24'h000000, hitAny ? rdMux : 8'h00};
    end
  end

  // Control register keeps the last write
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      ctl_reg <= CtlReset;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // Output data register
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      data_reg <= DataReset;
    end else if (wrData) begin
      data_reg <= avsWritedata[7:0];
    end
  end

  // Mode register
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      mode_reg <= ModeReset;
    end else if (wrMode) begin
      mode_reg <= avsWritedata[7:0];
    end
  end

  // FIFO feeds the EPP byte sender
  assign fifoBus.inValid = eppPush && accept;
  assign fifoBus.inData = avsWritedata[7:0];
  ppport_fifo #(
    .Width(FifoWidth),
    .Depth(FifoDepth)
  ) uFifo (
    .clk(clk),
    .rstn(rstnInt),
    .port(fifoBus.fifo)
  );

  // EPP sender: setup, strobe pulse, then wait for busy to drop
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PP_IDLE: begin
        if (fifoBus.outValid && eppMode) begin
          state_next = PP_SETUP;
        end
      end
      PP_SETUP: begin
        if (!busySync) begin
          state_next = PP_PULSE;
        end
      end
      PP_PULSE: begin
        if (pulseCnt_reg == 4'h1) begin
          state_next = PP_WAIT;
        end
      end
      PP_WAIT: begin
        if (!busySync) begin
          state_next = PP_IDLE;
        end
      end
      default: begin
        state_next = PP_IDLE;
      end
    endcase
  end
  assign fifoBus.outReady = (state_reg == PP_IDLE) && eppMode;

  wire fifoPop = fifoBus.outValid && fifoBus.outReady;

  // Sender state
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      state_reg <= PP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Byte in flight, taken as the FIFO pops
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      sendByte_reg <= 8'h00;
    end else if (fifoPop) begin
      sendByte_reg <= fifoBus.outData;
    end
  end

  // Strobe low only after data has had a setup cycle
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      pulseCnt_reg <= 4'h0;
      pulseStrobe_reg <= 1'b0;
    end else begin
      pulseStrobe_reg <= (state_next == PP_PULSE);
      pulseCnt_reg <= (state_reg == PP_SETUP) ? StrobeCycles :
                      (pulseCnt_reg != 4'h0 ? pulseCnt_reg - 4'h1 : 4'h0);
    end
  end

  // Pin outputs: decode of the control register, with strobe also driven low by the EPP pulse
  assign line_feed_out_n = ~ctl_reg[CtlFeed];
  assign data_strobe_out_n = ~(ctl_reg[CtlStrobe] | pulseStrobe_reg);
  assign peripheral_select_out_n = ~ctl_reg[CtlSelect];
  assign peripheral_init_out_n = ctl_reg[CtlInit];
  // Interrupt follows acknowledge low, gated by the enable bit
  assign port_irq_out = ctl_reg[CtlIrqEn] & ~ackSyncN;

  // Data bus drives unless reversed; EPP shows the byte in flight
  assign port_data_bus_out = eppMode ? sendByte_reg : data_reg;
  assign port_data_bus_oe = ~dirIn;
  // Open-drain ready: driven low only while an EPP push is stalled
  assign channel_ready_out = 1'b0;
  assign channel_ready_oe = pushStall;
endmodule
`default_nettype wire

// ### src/ppport_pkg.sv
// Package: register map, bit positions and reset values of the printer port
package ppport_pkg;
  localparam int unsigned AddrW = 3;
  // Word indices on the Avalon bus (byte address is four times the index)
  localparam logic [AddrW-1:0] RegData = 3'h0;
  localparam logic [AddrW-1:0] RegStatus = 3'h1;
  localparam logic [AddrW-1:0] RegControl = 3'h2;
  localparam logic [AddrW-1:0] RegMode = 3'h3;
  localparam logic [AddrW-1:0] RegFifo = 3'h4;
  // Control register bit positions
  localparam int unsigned CtlStrobe = 0;
  localparam int unsigned CtlFeed = 1;
  localparam int unsigned CtlInit = 2;
  localparam int unsigned CtlSelect = 3;
  localparam int unsigned CtlIrqEn = 4;
  localparam int unsigned CtlDirIn = 5;
  // Status register bit positions
  localparam int unsigned StFault = 3;
  localparam int unsigned StOnline = 4;
  localparam int unsigned StPaper = 5;
  localparam int unsigned StAck = 6;
  localparam int unsigned StBusy = 7;
  // Mode register: bit 0 selects EPP wait stretching
  localparam int unsigned ModeEpp = 0;
  // Reset values: init low is avoided, control resets to 8'h04 (init high)
  localparam logic [7:0] CtlReset = 8'h04;
  localparam logic [7:0] DataReset = 8'h00;
  localparam logic [7:0] ModeReset = 8'h00;
  // FIFO geometry
  localparam int unsigned FifoWidth = 8;
  localparam int unsigned FifoDepth = 8;
  // EPP strobe pulse length in cycles
  localparam logic [3:0] StrobeCycles = 4'h4;
  typedef enum logic [1:0] {
    PP_IDLE = 2'b00,
    PP_SETUP = 2'b01,
    PP_PULSE = 2'b11,
    PP_WAIT = 2'b10
  } ppport_state_t;
endpackage

// ### src/ppport_fifo_if.sv
// Interface: valid/ready carrier between the port core and its FIFO
`timescale 1ns/1ps
`default_nettype none
interface ppport_fifo_if;
  logic inValid;
  logic inReady;
  logic [7:0] inData;
  logic outValid;
  logic outReady;
  logic [7:0] outData;
  logic [3:0] level;
  modport fifo (input inValid, input inData, output inReady,
    output outValid, output outData, input outReady, output level);
  modport core (output inValid, output inData, input inReady,
    input outValid, input outData, output outReady, input level);
endinterface
`default_nettype wire

// ### src/ppport_fifo.sv
// Module: parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ppport_fifo #(
  parameter int unsigned Width = 8,
  parameter int unsigned Depth = 8
) (
  input wire logic clk,
  input wire logic rstn,
  ppport_fifo_if.fifo port
);
  localparam int unsigned PtrW = $clog2(Depth);
  logic [Width-1:0] mem [Depth];
  logic [PtrW-1:0] wrPtr_reg;
  logic [PtrW-1:0] rdPtr_reg;
  logic [PtrW:0] count_reg;
  wire doWrite;
  wire doRead;

  // Handshakes are combinational; full and empty come from the count
  assign port.inReady = (count_reg != Depth[PtrW:0]);
  assign port.outValid = (count_reg != '0);
  assign port.outData = mem[rdPtr_reg];
  assign port.level = 4'(count_reg);
  assign doWrite = port.inValid && port.inReady;
  assign doRead = port.outValid && port.outReady;

  // Storage, written only at the write pointer
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= port.inData;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == PtrW'(Depth - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == PtrW'(Depth - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (PtrW+1)'(doWrite) - (PtrW+1)'(doRead);
    end
  end
endmodule
`default_nettype wire

// ### sim/ppport_core_props.sv
// Checker: port-level properties of the printer port core
`timescale 1ns/1ps
`default_nettype none
module ppport_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ppport_pkg::AddrW-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire logic line_feed_out_n,
  input wire logic data_strobe_out_n,
  input wire logic peripheral_select_out_n,
  input wire logic peripheral_init_out_n,
  input wire logic peripheral_busy_in,
  input wire logic peripheral_ack_in_n,
  input wire logic paper_out_in,
  input wire logic peripheral_online_in,
  input wire logic peripheral_fault_in_n,
  input wire logic port_data_bus_oe,
  input wire logic port_irq_out,
  input wire logic channel_ready_out,
  input wire logic channel_ready_oe
);
  import ppport_pkg::*;
  logic [7:0] wdReg;
  logic [4:0] pinsReg;
  logic [3:0] stCnt;
  // Accepted register accesses
  wire ctlWr = avsWrite && !avsWaitrequest && avsAddress == RegControl && avsByteenable[0];
  wire stRd = avsRead && !avsWaitrequest && avsAddress == RegStatus;
  wire [4:0] pins = {peripheral_busy_in, peripheral_ack_in_n, paper_out_in,
    peripheral_online_in, peripheral_fault_in_n};
  // Pin age: status is judged only once the synchronisers have settled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdReg <= 8'h00;
      pinsReg <= 5'h00;
      stCnt <= 4'h0;
    end else begin
      wdReg <= avsWritedata[7:0];
      pinsReg <= pins;
      stCnt <= (pins != pinsReg) ? 4'h0 : stCnt + {3'h0, stCnt != 4'hF};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_FEED: assert property (ctlWr |=> line_feed_out_n == !wdReg[CtlFeed])
    else $error("line feed does not follow control");
  AST_STROBE: assert property (ctlWr && avsWritedata[CtlStrobe] |=> !data_strobe_out_n)
    else $error("strobe not low after control write");
  AST_SELECT: assert property (ctlWr |=> peripheral_select_out_n == !wdReg[CtlSelect])
    else $error("select does not follow control");
  AST_INIT: assert property (ctlWr |=> peripheral_init_out_n == wdReg[CtlInit])
    else $error("init does not follow control");
  AST_BUSDIR: assert property (ctlWr |=> port_data_bus_oe == !wdReg[CtlDirIn])
    else $error("data bus direction wrong");
  AST_IRQ_GATE: assert property (ctlWr && !avsWritedata[CtlIrqEn] |=> !port_irq_out)
    else $error("interrupt raised while disabled");
  AST_IRQ_CAUSE: assert property (port_irq_out |->
    !$past(peripheral_ack_in_n, 2) || !$past(peripheral_ack_in_n, 3))
    else $error("interrupt without acknowledge");
  AST_STATUS: assert property (stRd && stCnt > 4'h6 |->
    avsReaddata[7:0] == {!peripheral_busy_in, peripheral_ack_in_n, paper_out_in,
    peripheral_online_in, peripheral_fault_in_n, 3'h0})
    else $error("status read does not match pins");
  AST_READY: assert property (channel_ready_oe |->
    avsWrite && avsWaitrequest && !channel_ready_out)
    else $error("ready line pulled without a stalled write");
  // Main scenarios reached
  cover property (ctlWr);
  cover property (stRd);
  cover property (channel_ready_oe);
  cover property (port_irq_out);
endmodule
bind ppport_core ppport_props i_ppport_props (.clk(clk), .rstn(rstn),
  .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
  .avsWaitrequest(avsWaitrequest), .line_feed_out_n(line_feed_out_n),
  .data_strobe_out_n(data_strobe_out_n), .peripheral_select_out_n(peripheral_select_out_n),
  .peripheral_init_out_n(peripheral_init_out_n), .peripheral_busy_in(peripheral_busy_in),
  .peripheral_ack_in_n(peripheral_ack_in_n), .paper_out_in(paper_out_in),
  .peripheral_online_in(peripheral_online_in), .peripheral_fault_in_n(peripheral_fault_in_n),
  .port_data_bus_oe(port_data_bus_oe), .port_irq_out(port_irq_out),
  .channel_ready_out(channel_ready_out), .channel_ready_oe(channel_ready_oe));
`default_nettype wire

// ### sim/ppport_printer.sv
// Partner model: printer taking strobed bytes with busy and acknowledge
`timescale 1ns/1ps
`default_nettype none
module ppport_printer (
  input wire logic clk,
  input wire logic strobeN,
  input wire logic [7:0] dataIn,
  input wire logic [7:0] slowCycles,
  output logic busy,
  output logic ackN
);
  logic strobeOld = 1'b1;
  logic [7:0] busyCnt = 8'h00;
  logic [3:0] lowCnt = 4'h0;
  logic [7:0] rxQ[$];
  logic [3:0] widthQ[$];
  initial begin
    busy = 1'b0;
    ackN = 1'b1;
  end
  // Byte taken at the falling strobe; busy for slowCycles, then one ack pulse
  always @(posedge clk) begin
    strobeOld <= strobeN;
    lowCnt <= strobeN ? 4'h0 : lowCnt + 4'h1;
    ackN <= 1'b1;
    if (busyCnt != 8'h00) busyCnt <= busyCnt - 8'h01;
    if (strobeOld && !strobeN) begin
      rxQ.push_back(dataIn);
      busy <= 1'b1;
      busyCnt <= slowCycles;
    end else if (busy && busyCnt == 8'h00 && strobeN) begin
      busy <= 1'b0;
      ackN <= 1'b0;
    end
    if (!strobeOld && strobeN) widthQ.push_back(lowCnt);
  end
endmodule
`default_nettype wire

// ### sim/tb.sv
// Testbench: printer port core against a printer model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ppport_pkg::*;
  logic clk, rstn, avsRead, avsWrite, frc, sawStall, avsWaitrequest, avsResponseErr;
  logic [2:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, rdq;
  logic [3:0] avsByteenable;
  logic [4:0] fv;
  logic [7:0] slow, busOut;
  logic lf, st, sel, ini, oe, irq, cro, croe, pBusy, pAck;
  int nFail = 0, numChecks = 0, i;
  // Control rows: written value, expected {feed, strobe, select, init, drive}
  logic [12:0] ctlRows[7] = '{{8'h00, 5'h1D}, {8'h01, 5'h15}, {8'h02, 5'h0D},
    {8'h04, 5'h1F}, {8'h08, 5'h19}, {8'h24, 5'h1E}, {8'h2F, 5'h02}};
  // Status rows: {busy, ack_n, paper, online, fault_n}, expected status byte
  logic [12:0] stRows[7] = '{{5'h10, 8'h00}, {5'h00, 8'h80}, {5'h08, 8'hC0},
    {5'h04, 8'hA0}, {5'h02, 8'h90}, {5'h01, 8'h88}, {5'h0F, 8'hF8}};
  // Pins: the model answers busy and ack unless a test forces them
  wire busyPin = frc ? fv[4] : pBusy;
  wire ackPin = frc ? fv[3] : pAck;
  wire [7:0] busIn = oe ? busOut : 8'h3C;
  ppport_core i_ppport_core (.clk(clk), .rstn(rstn), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .avsResponseErr(avsResponseErr),
    .line_feed_out_n(lf), .data_strobe_out_n(st), .peripheral_select_out_n(sel),
    .peripheral_init_out_n(ini), .peripheral_busy_in(busyPin),
    .peripheral_ack_in_n(ackPin), .paper_out_in(fv[2]),
    .peripheral_online_in(fv[1]), .peripheral_fault_in_n(fv[0]),
    .port_data_bus_in(busIn), .port_data_bus_out(busOut), .port_data_bus_oe(oe),
    .port_irq_out(irq), .channel_ready_out(cro), .channel_ready_oe(croe));
  ppport_printer i_ppport_printer (.clk(clk), .strobeN(st), .dataIn(busOut),
    .slowCycles(slow), .busy(pBusy), .ackN(pAck));
  always #4 clk = ~clk;
  always @(posedge clk) if (croe === 1'b1) sawStall <= 1'b1;
  task automatic results();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    numChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWritedata <= {24'h0, d};
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (avsWaitrequest === 1'b0) break;
    end
    if (n == 3000) begin
      nFail++;
      results();
    end
    rdq = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  initial begin
    clk = 0; rstn = 0; avsAddress = 0; avsRead = 0; avsWrite = 0; avsWritedata = 0;
    avsByteenable = 4'hF; frc = 0; fv = 5'h0B; slow = 8'd8; sawStall = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ctlRows[k]) begin
      bus(1'b1, RegControl, ctlRows[k][12:5]);
      @(negedge clk);
      chk({3'h0, lf, st, sel, ini, oe}, {3'h0, ctlRows[k][4:0]}, "pins");
      bus(1'b0, RegControl, 8'h00);
      chk(rdq[7:0], ctlRows[k][12:5], "control");
    end
    $display("control rows done");
    frc <= 1'b1;
    foreach (stRows[k]) begin
      fv <= stRows[k][12:8];
      repeat (6) @(posedge clk);
      bus(1'b0, RegStatus, 8'h00);
      chk(rdq[7:0], stRows[k][7:0], "status");
    end
    $display("status rows done");
    // Interrupt raised by ack low only while enabled
    fv <= 5'h03;
    bus(1'b1, RegControl, 8'h14);
    repeat (4) @(negedge clk);
    chk({7'h0, irq}, 8'h01, "irq on");
    bus(1'b1, RegControl, 8'h04);
    @(negedge clk);
    chk({7'h0, irq}, 8'h00, "irq masked");
    $display("interrupt done");
    // Data both ways, then an unmapped address
    fv <= 5'h0B;
    frc <= 1'b0;
    bus(1'b1, RegData, 8'hA5);
    @(negedge clk);
    chk(busOut, 8'hA5, "data out");
    bus(1'b1, RegControl, 8'h24);
    repeat (3) @(posedge clk);
    bus(1'b0, RegData, 8'h00);
    chk(rdq[7:0], 8'h3C, "data in");
    bus(1'b1, 3'h7, 8'hFF);
    bus(1'b0, 3'h7, 8'h00);
    chk(rdq[7:0], 8'h00, "unmapped");
    bus(1'b0, RegControl, 8'h00);
    chk(rdq[7:0], 8'h24, "control kept");
    $display("data done");
    // EPP burst into a slow printer: FIFO fills and the ready line stalls
    bus(1'b1, RegControl, 8'h04);
    bus(1'b1, RegMode, 8'h01);
    i_ppport_printer.rxQ.delete();
    i_ppport_printer.widthQ.delete();
    slow <= 8'd60;
    for (i = 0; i < 10; i++) bus(1'b1, RegData, 8'h10 + 8'(i));
    for (i = 0; i < 3000 && i_ppport_printer.widthQ.size() < 10; i++) @(posedge clk);
    if (i_ppport_printer.widthQ.size() < 10) begin
      nFail++;
      results();
    end
    chk({7'h0, sawStall}, 8'h01, "stall");
    chk({6'h0, avsResponseErr, cro}, 8'h00, "error and ready level");
    for (i = 0; i < 10; i++) begin
      chk(i_ppport_printer.rxQ[i], 8'h10 + 8'(i), "byte");
      chk({4'h0, i_ppport_printer.widthQ[i]}, {4'h0, StrobeCycles}, "pulse");
    end
    $display("epp done");
    // Reset in mid-run returns the pins to their idle levels
    rstn <= 1'b0;
    @(negedge clk);
    chk({2'h0, lf, st, sel, ini, oe, irq}, 8'h3E, "reset pins");
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, RegControl, 8'h00);
    chk(rdq[7:0], CtlReset, "control reset");
    $display("reset done");
    results();
  end
endmodule
`default_nettype wire
